// File: include/ises_pkg.sv
// package: constants and carrier types for the interface signal event status block
package ises_pkg;

   // live signal positions in the 6-bit interface status
   localparam int SIG_W = 6;
   localparam int REG_W = 8;
   localparam int SW_HI_POS = 5;
   localparam int SW_LO_POS = 4;

   // reset values
   localparam logic [SIG_W-1:0] SIG_RST = 6'h00;
   localparam logic [REG_W-1:0] REG_RST = 8'h00;
   localparam logic [9:0] ERR_NONE = 10'h000;

   // error codes
   localparam logic [9:0] ERR_CMD_FIRST = 10'h064;   // 100
   localparam logic [9:0] ERR_CMD_LAST = 10'h06B;    // 107
   localparam logic [9:0] ERR_STR_LONG = 10'h069;    // 105
   localparam logic [9:0] ERR_EXE_FIRST = 10'h0C8;   // 200
   localparam logic [9:0] ERR_EXE_LAST = 10'h0E0;    // 224
   localparam logic [9:0] ERR_UNTERM = 10'h12C;      // 300
   localparam logic [9:0] ERR_DEADLOCK = 10'h12D;    // 301
   localparam logic [9:0] ERR_INTERRUPT = 10'h12E;   // 302

   // longest accepted string argument
   localparam int STR_MAX = 254;
   localparam logic [8:0] STR_MAX_LEN = 9'h0FE;

   // remote-control modes
   typedef enum logic [1:0] {
      ISES_MODE_TERMINAL = 2'b00,
      ISES_MODE_COMPUTER = 2'b01,
      ISES_MODE_PARALLEL = 2'b10
   } ises_mode_e;

   // register selector for the query port
   typedef enum logic [2:0] {
      ISES_SEL_HIST = 3'b000,
      ISES_SEL_HIST_EN = 3'b001,
      ISES_SEL_LOSS = 3'b010,
      ISES_SEL_LOSS_EN = 3'b011,
      ISES_SEL_ERROR = 3'b100
   } ises_sel_e;

   // query or enable-write request
   typedef struct packed {
      logic rd;
      logic wr;
      ises_sel_e sel;
      logic [REG_W-1:0] wdata;
   } ises_req_s;

   // error reporting events from the command parser
   typedef struct packed {
      logic cmd_err;
      logic [2:0] cmd_idx;
      logic str_len_chk;
      logic [8:0] str_len;
      logic exe_err;
      logic [4:0] exe_idx;
      logic read_unterm;
      logic deadlock;
      logic resp_interrupt;
   } ises_evt_s;

endpackage

// File: rtl/ises_top.sv
// module: interface signal history/loss status with one-entry error buffer
//
// Overview of operation
// - rising live signal sets its history bit; history read clears it
// - bits 7 and 6 of history and loss always read zero
// - history bits 5..4 are switches, 3..0 are leads, names per DCE/DTE
// - loss bit set when its switch turns off or its lead falls
// - loss bits stay latched until the loss register is read
// - summary set when any history bit and its enable are both set
// - summary also set by any enabled loss bit; it is an OR of both
// - error buffer holds one entry; a newer error overwrites it
// - error-available flag set while the buffer holds an entry
// - error query returns entry; only clear-error command empties it
// - terminal mode sends each error out immediately and stores it
// - computer and parallel modes only store errors, never send them
// - parse errors coded 100 through 107
// - string argument over 254 characters gives error 105
// - execution failures coded 200 through 224
// - response read before full message gives error 300, no response
// - deadlock gives error 301, response discarded, commands still run
// - new command before response fully read discards it, error 302
// - live status bit is 1 while its signal is active
`timescale 1ns/1ps

module ises_top
   import ises_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // live handshake signals, 1 = active
   input wire logic [SIG_W-1:0] intf_live,
   input wire logic dte_emul,
   // remote-control mode
   input wire ises_mode_e mode,
   // register query and enable write
   input wire ises_req_s req,
   output logic [REG_W-1:0] rdata,
   output logic rvalid,
   output logic [9:0] err_rdata,
   // error events and clear-error command
   input wire ises_evt_s evt,
   input wire logic clear_err,
   // response handling towards the controller
   output logic resp_suppress,
   output logic resp_discard,
   // status byte contributions
   output logic intf_summary,
   output logic err_avail,
   output logic [REG_W-1:0] live_status,
   output logic live_dte,
   // immediate error transmit in terminal mode
   output logic err_tx_valid,
   output logic [9:0] err_tx_code
);

   ////////////////////////////////////////////////////////////////////
   // state

   logic [SIG_W-1:0] live_q, next_live_q;
   logic [SIG_W-1:0] hist, next_hist;
   logic [SIG_W-1:0] loss, next_loss;
   logic [SIG_W-1:0] hist_en, next_hist_en;
   logic [SIG_W-1:0] loss_en, next_loss_en;
   logic [9:0] err_code, next_err_code;
   logic err_full, next_err_full;
   logic [REG_W-1:0] next_rdata;
   logic next_rvalid;
   logic [9:0] next_err_rdata;
   logic next_summary;
   logic [REG_W-1:0] next_live_status;
   logic next_live_dte;
   logic next_tx_valid;
   logic [9:0] next_tx_code;
   logic next_suppress, next_discard;

   // pads a 6-bit field into an 8-bit register with bits 7..6 zero
   function automatic logic [REG_W-1:0] pad_reg(input logic [SIG_W-1:0] v);
      pad_reg = {2'b00, v};
   endfunction

   // highest-priority error raised this cycle; zero when none
   function automatic logic [9:0] pick_err(input ises_evt_s e);
      pick_err = ERR_NONE;
      if (e.cmd_err) begin
         pick_err = ERR_CMD_FIRST + {7'h00, e.cmd_idx};
      end
      if (e.str_len_chk && (e.str_len > STR_MAX_LEN)) begin
         pick_err = ERR_STR_LONG;
      end
      if (e.exe_err) begin
         pick_err = (e.exe_idx > 5'h18) ? ERR_EXE_LAST
                                         : ERR_EXE_FIRST + {5'h00, e.exe_idx};
      end
      if (e.read_unterm) begin
         pick_err = ERR_UNTERM;
      end
      if (e.deadlock) begin
         pick_err = ERR_DEADLOCK;
      end
      if (e.resp_interrupt) begin
         pick_err = ERR_INTERRUPT;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // edge capture and clear-on-read

   logic [SIG_W-1:0] rise, fall;
   logic rd_hist, rd_loss;
   logic [9:0] new_err;

   always_comb begin
      rise = intf_live & ~live_q;
      fall = ~intf_live & live_q;
      rd_hist = req.rd && (req.sel == ISES_SEL_HIST);
      rd_loss = req.rd && (req.sel == ISES_SEL_LOSS);
      next_live_q = intf_live;
      // a read clears only what it returned; a same-cycle edge survives
      next_hist = (rd_hist ? '0 : hist) | rise;
      next_loss = (rd_loss ? '0 : loss) | fall;
      next_hist_en = hist_en;
      next_loss_en = loss_en;
      if (req.wr && (req.sel == ISES_SEL_HIST_EN)) begin
         next_hist_en = req.wdata[SIG_W-1:0];
      end
      if (req.wr && (req.sel == ISES_SEL_LOSS_EN)) begin
         next_loss_en = req.wdata[SIG_W-1:0];
      end
      // computed from next values so the summary tracks the registers
      next_summary = |(next_hist & next_hist_en) | |(next_loss & next_loss_en);
      next_live_status = pad_reg(intf_live);
      next_live_dte = dte_emul;
   end

   ////////////////////////////////////////////////////////////////////
   // error buffer, reporting and query readback

   always_comb begin
      new_err = pick_err(evt);
      next_err_code = err_code;
      next_err_full = err_full;
      if (clear_err) begin
         next_err_full = 1'b0;
      end
      // a new error beats a same-cycle clear so it is never lost
      if (new_err != ERR_NONE) begin
         next_err_code = new_err;
         next_err_full = 1'b1;
      end
      next_tx_valid = (new_err != ERR_NONE) && (mode == ISES_MODE_TERMINAL);
      next_tx_code = new_err;
      next_suppress = evt.read_unterm;
      next_discard = evt.deadlock || evt.resp_interrupt;
      next_rvalid = req.rd;
      next_rdata = REG_RST;
      next_err_rdata = err_rdata;
      if (req.rd) begin
         unique case (req.sel)
            ISES_SEL_HIST: next_rdata = pad_reg(hist);
            ISES_SEL_HIST_EN: next_rdata = pad_reg(hist_en);
            ISES_SEL_LOSS: next_rdata = pad_reg(loss);
            ISES_SEL_LOSS_EN: next_rdata = pad_reg(loss_en);
            ISES_SEL_ERROR: next_err_rdata = err_full ? err_code : ERR_NONE;
            default: next_rdata = REG_RST;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         live_q <= SIG_RST;
         hist <= SIG_RST;
         loss <= SIG_RST;
         hist_en <= SIG_RST;
         loss_en <= SIG_RST;
         err_code <= ERR_NONE;
         err_full <= 1'b0;
         rdata <= REG_RST;
         rvalid <= 1'b0;
         err_rdata <= ERR_NONE;
         intf_summary <= 1'b0;
         live_status <= REG_RST;
         live_dte <= 1'b0;
         err_tx_valid <= 1'b0;
         err_tx_code <= ERR_NONE;
         resp_suppress <= 1'b0;
         resp_discard <= 1'b0;
      end else begin
         live_q <= next_live_q;
         hist <= next_hist;
         loss <= next_loss;
         hist_en <= next_hist_en;
         loss_en <= next_loss_en;
         err_code <= next_err_code;
         err_full <= next_err_full;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         err_rdata <= next_err_rdata;
         intf_summary <= next_summary;
         live_status <= next_live_status;
         live_dte <= next_live_dte;
         err_tx_valid <= next_tx_valid;
         err_tx_code <= next_tx_code;
         resp_suppress <= next_suppress;
         resp_discard <= next_discard;
      end
   end

   assign err_avail = err_full;

endmodule

// File: testbench/ises_chk.sv
// assertions on the status block ports
`timescale 1ns/1ps
module ises_chk
   import ises_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // stimulus seen by the block
   input wire logic [SIG_W-1:0] intf_live,
   input wire ises_mode_e mode,
   input wire ises_req_s req,
   input wire ises_evt_s evt,
   input wire logic clear_err,
   // block outputs
   input wire logic [REG_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic resp_suppress,
   input wire logic resp_discard,
   input wire logic err_avail,
   input wire logic [REG_W-1:0] live_status,
   input wire logic err_tx_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rd_answer: assert property (req.rd |=> rvalid)
      else $error("query not answered");
   a_unused_zero: assert property (rvalid |-> rdata[7:6] == 2'b00)
      else $error("unused read bits set");
   // the first edge after reset has no valid past sample
   a_live_copy: assert property ($past(rst_n) |-> live_status == {2'b00, $past(intf_live)})
      else $error("live status mismatch");
   a_err_raise: assert property (evt.exe_err |=> err_avail)
      else $error("error flag not raised");
   a_err_hold: assert property (err_avail && !clear_err |=> err_avail)
      else $error("error flag dropped");
   a_clear_drop: assert property (clear_err && evt == '0 |=> !err_avail)
      else $error("error flag not cleared");
   a_tx_quiet: assert property (mode != ISES_MODE_TERMINAL |=> !err_tx_valid)
      else $error("error sent outside terminal mode");
   a_tx_term: assert property (mode == ISES_MODE_TERMINAL && evt.cmd_err |=> err_tx_valid)
      else $error("terminal error not sent");
   a_unterm_supp: assert property (evt.read_unterm |=> resp_suppress)
      else $error("response not suppressed");
   a_resp_drop: assert property (evt.deadlock || evt.resp_interrupt |=> resp_discard)
      else $error("response not discarded");
   c_hist_read: cover property (req.rd && req.sel == ISES_SEL_HIST);
   c_tx: cover property (err_tx_valid);
   c_discard: cover property (resp_discard);
endmodule
bind ises_top ises_chk u_chk(.*);

// File: testbench/ises_ctrl.sv
// remote controller model: queries, enable writes, error events
`timescale 1ns/1ps
module ises_ctrl
   import ises_pkg::*;
(
   // clock
   input wire logic clk,
   // requests towards the block
   output ises_req_s req,
   output ises_evt_s evt,
   output logic clear_err
);
   initial begin
      req = '0;
      evt = '0;
      clear_err = 1'b0;
   end
   // called at a rising edge; every request is a one-cycle pulse
   task automatic access(input logic w, input ises_sel_e s, input logic [7:0] d);
      req <= '{rd: !w, wr: w, sel: s, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic event_pulse(input ises_evt_s e);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask
   // a pending error is cleared before the next command is sent
   task automatic clear_pending();
      clear_err <= 1'b1;
      @(posedge clk);
      clear_err <= 1'b0;
   endtask
endmodule

// File: testbench/test_intf_signal_event_status.sv
// testbench: event latching, summary, error buffer and reporting
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_intf_signal_event_status
   import ises_pkg::*;
   ;
   logic clk, rst_n, dte_emul, clear_err, rvalid, resp_suppress, resp_discard;
   logic intf_summary, err_avail, live_dte, err_tx_valid;
   logic [SIG_W-1:0] intf_live;
   logic [REG_W-1:0] rdata, live_status;
   logic [9:0] err_rdata, err_tx_code;
   ises_mode_e mode;
   ises_req_s req;
   ises_evt_s evt;
   ises_evt_s e;
   int fail_count, comparisons, i;
   ises_top dut(.*);
   ises_ctrl ctrl(.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic rd(input ises_sel_e s, input logic [7:0] x, input string n);
      @(posedge clk);
      ctrl.access(1'b0, s, 8'h00);
      #1;
      `CHK(n, x, rdata)
   endtask
   task automatic wr(input ises_sel_e s, input logic [7:0] d);
      @(posedge clk);
      ctrl.access(1'b1, s, d);
   endtask
   task automatic errq(input logic [9:0] x);
      @(posedge clk);
      ctrl.access(1'b0, ISES_SEL_ERROR, 8'h00);
      #1;
      `CHK("err code", x, err_rdata)
   endtask
   task automatic ev(input ises_evt_s v);
      @(posedge clk);
      ctrl.event_pulse(v);
      #1;
   endtask
   task automatic live(input logic [5:0] v, input logic s, input string n);
      @(posedge clk);
      intf_live <= v;
      @(posedge clk);
      #1;
      `CHK(n, s, intf_summary)
   endtask
   // the tests need well under 500 cycles, so 2000 means a hang
   initial begin
      #10000;
      fail_count++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      intf_live = '0;
      dte_emul = 1'b0;
      mode = ISES_MODE_TERMINAL;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      intf_live <= 6'h3f;
      dte_emul <= 1'b1;
      rd(ISES_SEL_HIST, 8'h3f, "hist rise");
      `CHK("live", 8'h3f, live_status)
      `CHK("dte", 1'b1, live_dte)
      rd(ISES_SEL_HIST, 8'h00, "hist clear");
      @(posedge clk);
      intf_live <= 6'h00;
      rd(ISES_SEL_LOSS, 8'h3f, "loss fall");
      rd(ISES_SEL_LOSS, 8'h00, "loss clear");
      $display("test latching done");
      wr(ISES_SEL_HIST_EN, 8'h01);
      wr(ISES_SEL_LOSS_EN, 8'h02);
      rd(ISES_SEL_HIST_EN, 8'h01, "hist en");
      live(6'h01, 1'b1, "sum hist");
      rd(ISES_SEL_HIST, 8'h01, "hist b0");
      live(6'h02, 1'b0, "sum masked");
      live(6'h00, 1'b1, "sum loss");
      rd(ISES_SEL_LOSS, 8'h03, "loss b1");
      `CHK("sum off", 1'b0, intf_summary)
      rd(ISES_SEL_HIST, 8'h02, "hist b1");
      // the rising edge lands in the same cycle as the clearing read
      @(posedge clk);
      intf_live <= 6'h04;
      ctrl.access(1'b0, ISES_SEL_HIST, 8'h00);
      rd(ISES_SEL_HIST, 8'h04, "hist kept");
      $display("test summary done");
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         mode <= ises_mode_e'(i);
         e = '0;
         e.cmd_err = 1'b1;
         e.cmd_idx = 3'(i + 5);
         ev(e);
         `CHK("tx", (i == 0), err_tx_valid)
         `CHK("avail", 1'b1, err_avail)
         if (i == 0) `CHK("tx code", 10'd105, err_tx_code)
         e = '0;
         e.exe_err = 1'b1;
         e.exe_idx = 5'(i * 12);
         ev(e);
         errq(10'd200 + 10'(i * 12));
         `CHK("avail kept", 1'b1, err_avail)
         e = '0;
         e[2 - i] = 1'b1;
         ev(e);
         `CHK("suppress", (i == 0), resp_suppress)
         `CHK("discard", (i != 0), resp_discard)
         errq(10'd300 + 10'(i));
         @(posedge clk);
         ctrl.clear_pending();
         #1;
         `CHK("cleared", 1'b0, err_avail)
      end
      e = '0;
      e.str_len_chk = 1'b1;
      e.str_len = 9'd254;
      ev(e);
      `CHK("len ok", 1'b0, err_avail)
      e.str_len = 9'd255;
      ev(e);
      errq(10'd105);
      $display("test errors done");
      finish_test();
   end
endmodule
